// file: verilog/mtu_pkg.sv
// Constants, state records and carriers for the multimode timer unit
package mtu_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SRC_HZ = 5_000_000;
  localparam logic [3:0]  DIV_LAST = 4'(CLK_HZ / SRC_HZ - 1);
  // Register byte offsets
  localparam logic [7:0]  OFS_COUNT_START = 8'h00;
  localparam logic [7:0]  OFS_A_MODE      = 8'h04;
  localparam logic [7:0]  OFS_A_COUNT     = 8'h08;
  localparam logic [7:0]  OFS_B_MODE      = 8'h0C;
  localparam logic [7:0]  OFS_B_COUNT     = 8'h10;
  localparam logic [7:0]  OFS_IRQ         = 8'h14;
  localparam logic [7:0]  OFS_MOTOR       = 8'h18;
  // Field positions
  localparam int unsigned START_A_BIT  = 0;
  localparam int unsigned START_B_BIT  = 1;
  localparam int unsigned SW_TRIG_BIT  = 2;
  localparam int unsigned UP_DOWN_BIT  = 2;
  localparam int unsigned EXT_TRIG_BIT = 3;
  localparam int unsigned OVF_BIT      = 3;
  localparam int unsigned IR_A_BIT     = 0;
  localparam int unsigned IR_B_BIT     = 1;
  localparam int unsigned NMI_EN_BIT   = 0;
  localparam int unsigned SHUT_EN_BIT  = 1;
  localparam int unsigned MOT_USE_BIT  = 2;
  localparam int unsigned MOT_OE_BIT   = 3;
  // Values
  localparam logic [15:0] CNT_RST   = 16'hFFFF;
  localparam logic [15:0] RD_UNDER  = 16'hFFFF;
  localparam logic [15:0] RD_OVER   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {A_TIMER, A_EVENT, A_ONESHOT, A_PWM} mtu_a_mode_t;
  typedef enum logic [1:0] {B_TIMER, B_EVENT, B_PERIOD, B_WIDTH} mtu_b_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mtu_wb_req_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } mtu_motor_t;

  typedef struct packed {
    logic prev;
  } mtu_edge_st_t;

  typedef struct packed {
    logic [3:0]  div;
    logic        ack;
    logic [31:0] rdat;
    logic        a_run;
    mtu_a_mode_t a_mode;
    logic        a_ud;
    logic        a_ext;
    logic [15:0] a_cnt;
    logic [15:0] a_rel;
    logic        a_out;
    logic        a_shot;
    logic        a_pend;
    logic        a_rld_nxt;
    logic        a_reload;
    logic        a_ovf;
    logic        a_stop_ir;
    logic        b_run;
    mtu_b_mode_t b_mode;
    logic [15:0] b_cnt;
    logic [15:0] b_rel;
    logic        b_reload;
    logic        b_ovf;
    logic        b_ovf_age;
    logic        b_first;
    logic        ir_a;
    logic        ir_b;
    logic [3:0]  mot;
    logic        shut;
  } mtu_st_t;
endpackage : mtu_pkg

// file: verilog/mtu_edge.sv
// Edge detector for one synchronous pin
`timescale 1ns/100ps
module mtu_edge
  import mtu_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sig_i,
  output logic      rise_o,
  output logic      fall_o
);
  mtu_edge_st_t q, n;

  always_comb
  begin
    n.prev = sig_i;
    rise_o = sig_i & ~q.prev;
    fall_o = ~sig_i & q.prev;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      q <= '0;
    else
      q <= n;
  end

  chk_edge_excl : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(rise_o && fall_o)) else $error("Rise and fall seen together");
endmodule : mtu_edge

// file: verilog/mtu_top.sv
// Multimode timer unit: one group A channel, one group B channel, motor shutdown
// Functional notes
// - All channels halted after reset; counting starts when software sets start bit.
// - Timer mode read: live count, FFFFh during reload, written value if stopped.
// - Event mode read during reload: FFFFh after underflow, 0000h after overflow.
// - One-shot stop while counting halts, reloads counter, drives output low.
// - One-shot stop while counting sets interrupt flag one clock later.
// - External one-shot trigger starts pulse within one count source clock.
// - Entering one-shot from reset, timer or event mode sets interrupt flag.
// - Retrigger during one-shot: decrement once, reload, keep counting.
// - Entering PWM from reset, timer or event mode sets interrupt flag.
// - PWM stop with output high: output low, flag set; low: nothing changes.
// - Group B timer/event read: live count, FFFFh in reload, written value stopped.
// - Overflow bit clears only once set and a count tick passed while running.
// - Measurement first edge loads undefined count without an interrupt.
// - Changing measure select while running sets flag; same value leaves it.
// - Width mode measures every pulse, both levels, with no level marking.
// - Overflow coinciding with valid edge: one interrupt, edge ignored.
// - Low shutdown input with all four enables places motor outputs high-Z.
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module mtu_top
  import mtu_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  sys_rst_i,
  input  mtu_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  input  wire logic  a_trig_pin_i,
  input  wire logic  b_pulse_i,
  input  wire logic  nmi_n_i,
  output logic        a_out_o,
  output logic        ir_a_o,
  output logic        ir_b_o,
  output mtu_motor_t  motor_o
);
  mtu_st_t q, n;
  logic    a_rise;
  logic    b_rise;
  logic    b_fall;
  logic    tick;
  logic    acc;
  logic    wr;
  logic    seta;
  logic    setb;
  logic    a_trig;
  logic    b_edge;
  logic    b_ovf_now;
  logic    b_meas;
  logic [15:0] a_rd;
  logic [15:0] b_rd;

  mtu_edge u_a_edge (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sig_i     (a_trig_pin_i),
    .rise_o    (a_rise),
    .fall_o    ()
  );

  mtu_edge u_b_edge (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sig_i     (b_pulse_i),
    .rise_o    (b_rise),
    .fall_o    (b_fall)
  );

  assign tick   = (q.div == DIV_LAST);
  assign acc    = wb_i.cyc & wb_i.stb & ~q.ack;
  assign wr     = acc & wb_i.we & (|wb_i.sel);
  assign a_trig = q.a_ext ? a_rise : (wr && wb_i.adr == OFS_COUNT_START
                                      && wb_i.dat[SW_TRIG_BIT]);
  assign b_meas = (q.b_mode == B_PERIOD) || (q.b_mode == B_WIDTH);
  // Width mode takes both edges and keeps no polarity record
  assign b_edge = (q.b_mode == B_WIDTH) ? (b_rise | b_fall) : b_rise;
  assign b_ovf_now = q.b_run && b_meas && tick && q.b_cnt == CNT_MAX;

  always_comb
  begin
    n    = q;
    seta = 1'b0;
    setb = 1'b0;
    a_rd = q.a_cnt;
    b_rd = q.b_cnt;
    n.ack       = acc;
    n.div       = tick ? 4'h0 : q.div + 4'h1;
    n.a_reload  = 1'b0;
    n.b_reload  = 1'b0;
    n.a_stop_ir = 1'b0;
    seta        = q.a_stop_ir;
    n.shut = q.mot[NMI_EN_BIT] & q.mot[SHUT_EN_BIT] & q.mot[MOT_USE_BIT]
             & q.mot[MOT_OE_BIT] & ~nmi_n_i;

    // Channel A counting
    if (a_trig && q.a_run && q.a_mode == A_ONESHOT)
      n.a_pend = 1'b1;
    if (q.a_run)
    begin
      unique case (q.a_mode)
        A_TIMER:
          if (tick)
          begin
            if (q.a_cnt == CNT_ZERO)
            begin
              n.a_cnt = q.a_rel;
              n.a_reload = 1'b1;
              n.a_ovf = 1'b0;
              seta = 1'b1;
            end
            else
              n.a_cnt = q.a_cnt - 16'h0001;
          end
        A_EVENT:
          if (a_rise)
          begin
            if (q.a_ud ? q.a_cnt == CNT_MAX : q.a_cnt == CNT_ZERO)
            begin
              n.a_cnt = q.a_rel;
              n.a_reload = 1'b1;
              n.a_ovf = q.a_ud;
              seta = 1'b1;
            end
            else
              n.a_cnt = q.a_ud ? q.a_cnt + 16'h0001 : q.a_cnt - 16'h0001;
          end
        A_ONESHOT:
          if (tick)
          begin
            if (q.a_pend && !q.a_shot)
            begin
              // Trigger acts on the next count source tick
              n.a_pend = 1'b0;
              n.a_shot = 1'b1;
              n.a_out = 1'b1;
              n.a_cnt = q.a_rel;
            end
            else if (q.a_pend)
            begin
              n.a_pend = 1'b0;
              n.a_rld_nxt = 1'b1;
              n.a_cnt = q.a_cnt - 16'h0001;
            end
            else if (q.a_rld_nxt)
            begin
              n.a_rld_nxt = 1'b0;
              n.a_cnt = q.a_rel;
            end
            else if (q.a_shot && q.a_cnt == CNT_ZERO)
            begin
              n.a_shot = 1'b0;
              n.a_out = 1'b0;
              n.a_cnt = q.a_rel;
              n.a_reload = 1'b1;
              seta = 1'b1;
            end
            else if (q.a_shot)
              n.a_cnt = q.a_cnt - 16'h0001;
          end
        A_PWM:
          if (tick)
          begin
            if (q.a_cnt == CNT_ZERO)
            begin
              n.a_cnt = q.a_rel;
              n.a_out = ~q.a_out;
              n.a_reload = 1'b1;
              seta = q.a_out;
            end
            else
              n.a_cnt = q.a_cnt - 16'h0001;
          end
      endcase
    end

    // Channel B counting
    if (q.b_run)
    begin
      if (b_meas)
      begin
        if (tick && q.b_ovf)
          n.b_ovf_age = 1'b1;
        if (b_ovf_now)
        begin
          // Coinciding edge is dropped, only one request raised
          n.b_cnt = CNT_ZERO;
          n.b_ovf = 1'b1;
          n.b_ovf_age = 1'b0;
          setb = 1'b1;
        end
        else if (b_edge)
        begin
          n.b_rel = q.b_cnt;
          n.b_cnt = CNT_ZERO;
          n.b_first = 1'b0;
          setb = ~q.b_first;
        end
        else if (tick)
          n.b_cnt = q.b_cnt + 16'h0001;
      end
      else if (q.b_mode == B_TIMER ? tick : b_rise)
      begin
        if (q.b_cnt == CNT_ZERO)
        begin
          n.b_cnt = q.b_rel;
          n.b_reload = 1'b1;
          setb = 1'b1;
        end
        else
          n.b_cnt = q.b_cnt - 16'h0001;
      end
    end

    // Register writes override counting
    if (wr)
    begin
      unique case (wb_i.adr)
        OFS_COUNT_START:
        begin
          n.a_run = wb_i.dat[START_A_BIT];
          n.b_run = wb_i.dat[START_B_BIT];
          if (q.a_run && !wb_i.dat[START_A_BIT])
          begin
            n.a_pend = 1'b0;
            n.a_rld_nxt = 1'b0;
            if (q.a_mode == A_ONESHOT && q.a_shot)
            begin
              n.a_shot = 1'b0;
              n.a_cnt = q.a_rel;
              n.a_out = 1'b0;
              n.a_stop_ir = 1'b1;
            end
            else if (q.a_mode == A_PWM && q.a_out)
            begin
              n.a_out = 1'b0;
              seta = 1'b1;
            end
          end
          if (!q.b_run && wb_i.dat[START_B_BIT])
            n.b_first = 1'b1;
        end
        OFS_A_MODE:
        begin
          n.a_mode = mtu_a_mode_t'(wb_i.dat[1:0]);
          n.a_ud = wb_i.dat[UP_DOWN_BIT];
          n.a_ext = wb_i.dat[EXT_TRIG_BIT];
          // Reset mode is timer, so first selection also raises it
          if (wb_i.dat[1] && !q.a_mode[1])
            seta = 1'b1;
        end
        OFS_A_COUNT:
        begin
          n.a_rel = wb_i.dat[15:0];
          if (!q.a_run)
            n.a_cnt = wb_i.dat[15:0];
        end
        OFS_B_MODE:
        begin
          n.b_mode = mtu_b_mode_t'(wb_i.dat[1:0]);
          if (q.b_run && b_meas && wb_i.dat[1:0] != q.b_mode)
            setb = 1'b1;
          if (!wb_i.dat[OVF_BIT] && q.b_ovf_age)
          begin
            n.b_ovf = 1'b0;
            n.b_ovf_age = 1'b0;
          end
        end
        OFS_B_COUNT:
        begin
          n.b_rel = wb_i.dat[15:0];
          if (!q.b_run)
            n.b_cnt = wb_i.dat[15:0];
        end
        OFS_IRQ:
        begin
          n.ir_a = q.ir_a & ~wb_i.dat[IR_A_BIT];
          n.ir_b = q.ir_b & ~wb_i.dat[IR_B_BIT];
        end
        OFS_MOTOR:
          n.mot = wb_i.dat[3:0];
        default:
          n.mot = q.mot;
      endcase
    end
    // Set beats a clear in the same cycle
    n.ir_a = n.ir_a | seta;
    n.ir_b = n.ir_b | setb;

    // Counter readback
    if (q.a_reload && q.a_mode != A_PWM && q.a_mode != A_ONESHOT)
      a_rd = q.a_ovf ? RD_OVER : RD_UNDER;
    if (b_meas)
      b_rd = q.b_rel;
    else if (q.b_reload)
      b_rd = RD_UNDER;
    unique case (wb_i.adr)
      OFS_COUNT_START: n.rdat = {30'h0, q.b_run, q.a_run};
      OFS_A_MODE:      n.rdat = {28'h0, q.a_ext, q.a_ud, q.a_mode};
      OFS_A_COUNT:     n.rdat = {16'h0, a_rd};
      OFS_B_MODE:      n.rdat = {28'h0, q.b_ovf, 1'b0, q.b_mode};
      OFS_B_COUNT:     n.rdat = {16'h0, b_rd};
      OFS_IRQ:         n.rdat = {30'h0, q.ir_b, q.ir_a};
      OFS_MOTOR:       n.rdat = {28'h0, q.mot};
      default:         n.rdat = RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.a_cnt <= CNT_RST;
      q.a_rel <= CNT_RST;
      q.b_cnt <= CNT_RST;
      q.b_rel <= CNT_RST;
    end
    else
      q <= n;
  end

  assign wb_dat_o  = q.rdat;
  assign wb_ack_o  = q.ack;
  assign a_out_o   = q.a_out;
  assign ir_a_o    = q.ir_a;
  assign ir_b_o    = q.ir_b;
  assign motor_o.out = {3{q.a_out}};
  assign motor_o.oe  = {3{q.mot[MOT_USE_BIT] & q.mot[MOT_OE_BIT] & ~q.shut}};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_reset_halt : assert property ($past(sys_rst_i) |-> !q.a_run && !q.b_run)
    else $error("Channel running right after reset");
  chk_timer_read : assert property (acc && !wb_i.we && wb_i.adr == OFS_A_COUNT
    && q.a_mode == A_TIMER && q.a_reload |=> wb_ack_o && wb_dat_o[15:0] == RD_UNDER)
    else $error("Timer reload read not FFFF");
  chk_event_over : assert property (acc && !wb_i.we && wb_i.adr == OFS_A_COUNT
    && q.a_mode == A_EVENT && q.a_reload && q.a_ovf |=> wb_dat_o[15:0] == RD_OVER)
    else $error("Event overflow read not 0000");
  chk_shot_stop : assert property (wr && wb_i.adr == OFS_COUNT_START
    && !wb_i.dat[START_A_BIT] && q.a_run && q.a_mode == A_ONESHOT && q.a_shot
    |=> !a_out_o && q.a_cnt == q.a_rel && !q.a_run ##1 ir_a_o)
    else $error("One-shot stop misbehaved");
  chk_trig_delay : assert property (q.a_run && q.a_mode == A_ONESHOT && !q.a_shot
    && a_trig && !q.a_pend && !wr |-> ##[1:5] q.a_shot)
    else $error("One-shot trigger too slow");
  chk_mode_irq : assert property (wr && wb_i.adr == OFS_A_MODE && wb_i.dat[1]
    && !q.a_mode[1] |=> ir_a_o)
    else $error("Mode entry left flag clear");
  chk_pwm_stop : assert property (wr && wb_i.adr == OFS_COUNT_START
    && !wb_i.dat[START_A_BIT] && q.a_run && q.a_mode == A_PWM && q.a_out
    |=> !a_out_o && ir_a_o)
    else $error("PWM stop misbehaved");
  chk_ovf_hold : assert property (wr && wb_i.adr == OFS_B_MODE
    && !wb_i.dat[OVF_BIT] && q.b_ovf && !q.b_ovf_age && !b_ovf_now |=> q.b_ovf)
    else $error("Overflow bit cleared too early");
  chk_coincide : assert property (b_ovf_now && b_edge
    |=> q.b_ovf && q.b_cnt == CNT_ZERO && q.b_rel == $past(q.b_rel))
    else $error("Coinciding edge recognised");
  chk_shutdown : assert property (q.mot == 4'hF && !nmi_n_i |=> motor_o.oe == 3'h0)
    else $error("Motor pins not released");
endmodule : mtu_top

// file: testbench/mtu_pin_model.sv
// Far-side pin model: trigger source, measured pulse and shutdown input
`timescale 1ns/100ps
module mtu_pin_model
(
  input  wire logic clk_i,
  output logic      trig_o,
  output logic      pulse_o,
  output logic      nmi_n_o
);
  int unsigned now  = 0;
  int unsigned last = 0;

  initial
  begin
    trig_o  = 1'b0;
    pulse_o = 1'b0;
    nmi_n_o = 1'b1;
  end

  always @(posedge clk_i)
    now <= now + 1;

  // Two-clock high level so the edge detector cannot miss it
  task automatic trig();
    @(posedge clk_i);
    while (now - last < 8)
      @(posedge clk_i);
    trig_o <= 1'b1;
    last = now;
    repeat (2) @(posedge clk_i);
    trig_o <= 1'b0;
  endtask : trig

  task automatic set_pins(input logic p, input logic n);
    @(posedge clk_i);
    pulse_o <= p;
    nmi_n_o <= n;
  endtask : set_pins
endmodule : mtu_pin_model

// file: testbench/multimode_timer_unit_test.sv
// Self-checking bench for the multimode timer unit
`timescale 1ns/100ps
module multimode_timer_unit_test;
  import mtu_pkg::*;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  mtu_wb_req_t wb        = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        a_trig;
  logic        b_pulse;
  logic        nmi_n;
  logic        a_out_o;
  logic        ir_a_o;
  logic        ir_b_o;
  mtu_motor_t  motor_o;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  mtu_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .a_trig_pin_i(a_trig), .b_pulse_i(b_pulse), .nmi_n_i(nmi_n),
    .a_out_o(a_out_o), .ir_a_o(ir_a_o), .ir_b_o(ir_b_o), .motor_o(motor_o));
  mtu_pin_model pins (.clk_i(clk_i), .trig_o(a_trig), .pulse_o(b_pulse), .nmi_n_o(nmi_n));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Holds the request until ack is sampled high, then one idle cycle follows
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 16);
    rd = wb_dat_o;
    wb <= '0;
    chk("bus ack", 32'(n < 16), 32'h1);
  endtask : xfer

  task automatic wait_lvl(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((s == 0 ? a_out_o : s == 1 ? ir_a_o : ir_b_o) !== lvl && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    chk($sformatf("level %0d", s),
        32'(s == 0 ? a_out_o : s == 1 ? ir_a_o : ir_b_o), 32'(lvl));
  endtask : wait_lvl

  // Read lands in the cycle right after the pin edge, while the reload flag stands
  task automatic edge_read(input logic b, input logic [7:0] a);
    fork
      if (b)
        pins.set_pins(1'b1, 1'b1);
      else
        pins.trig();
      begin
        @(posedge clk_i);
        xfer(1'b0, a, 32'h0);
      end
    join
  endtask : edge_read

  task automatic end_sim();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // Channel A mode and trigger settings are only written while A is stopped; the group B mode register is also written while B runs
  initial
  begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (12) @(negedge clk_i);
    chk("pins after reset", 32'({a_out_o, ir_a_o, ir_b_o, motor_o.oe}), 32'h0);
    xfer(1'b0, OFS_A_COUNT, 32'h0);
    chk("A count halted", rd, 32'(CNT_RST));
    xfer(1'b1, OFS_A_COUNT, 32'h10);
    xfer(1'b0, OFS_A_COUNT, 32'h0);
    chk("A stopped write", rd, 32'h10);
    xfer(1'b1, OFS_B_COUNT, 32'h20);
    xfer(1'b0, OFS_B_COUNT, 32'h0);
    chk("B stopped write", rd, 32'h20);
    xfer(1'b0, 8'h1C, 32'h0);
    chk("unmapped read", rd, RD_UNMAPPED);
    xfer(1'b1, OFS_COUNT_START, 32'h1);
    repeat (12) @(negedge clk_i);
    xfer(1'b0, OFS_A_COUNT, 32'h0);
    chk("A live count", 32'(rd < 32'h10 && rd > 32'h8), 32'h1);
    wait_lvl(1, 1'b1, 100);
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    $display("test registers done");
    // Entry into one-shot or PWM from timer or event mode
    for (int p = 0; p < 2; p++)
      for (int m = 2; m < 4; m++)
      begin
        xfer(1'b1, OFS_A_MODE, 32'(p));
        xfer(1'b1, OFS_IRQ, 32'h3);
        xfer(1'b1, OFS_A_MODE, 32'(m));
        @(negedge clk_i);
        chk("mode entry flag", 32'(ir_a_o), 32'h1);
      end
    $display("test mode entry done");
    xfer(1'b1, OFS_A_MODE, 32'hA);
    xfer(1'b1, OFS_A_COUNT, 32'h20);
    xfer(1'b1, OFS_IRQ, 32'h3);
    xfer(1'b1, OFS_COUNT_START, 32'h1);
    pins.trig();
    wait_lvl(0, 1'b1, 5);
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    @(negedge clk_i);
    chk("one-shot stop pin", 32'(a_out_o), 32'h0);
    chk("one-shot stop flag", 32'(ir_a_o), 32'h1);
    xfer(1'b0, OFS_A_COUNT, 32'h0);
    chk("one-shot stop reload", rd, 32'h20);
    // Retrigger well clear of the zero count
    xfer(1'b1, OFS_A_COUNT, 32'hA);
    xfer(1'b1, OFS_IRQ, 32'h3);
    xfer(1'b1, OFS_COUNT_START, 32'h1);
    pins.trig();
    wait_lvl(0, 1'b1, 5);
    repeat (30) @(negedge clk_i);
    pins.trig();
    repeat (32) @(negedge clk_i);
    chk("retriggered pulse", 32'(a_out_o), 32'h1);
    wait_lvl(0, 1'b0, 40);
    chk("retrigger end flag", 32'(ir_a_o), 32'h1);
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    $display("test one-shot done");
    xfer(1'b1, OFS_A_MODE, 32'h3);
    xfer(1'b1, OFS_A_COUNT, 32'h4);
    xfer(1'b1, OFS_IRQ, 32'h3);
    xfer(1'b1, OFS_COUNT_START, 32'h1);
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    @(negedge clk_i);
    chk("PWM stop low", 32'({a_out_o, ir_a_o}), 32'h0);
    xfer(1'b1, OFS_COUNT_START, 32'h1);
    wait_lvl(0, 1'b1, 40);
    chk("motor pins follow", 32'(motor_o.out), 32'h7);
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    @(negedge clk_i);
    chk("PWM stop high", 32'({a_out_o, ir_a_o}), 32'h1);
    $display("test PWM done");
    // Event counting: overflow counting up, then underflow counting down
    xfer(1'b1, OFS_A_MODE, 32'h5);
    xfer(1'b1, OFS_A_COUNT, 32'hFFFE);
    xfer(1'b1, OFS_COUNT_START, 32'h1);
    pins.trig();
    repeat (8) @(posedge clk_i);
    edge_read(1'b0, OFS_A_COUNT);
    chk("event overflow read", rd, 32'(RD_OVER));
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    xfer(1'b1, OFS_A_MODE, 32'h1);
    xfer(1'b1, OFS_A_COUNT, 32'h0);
    xfer(1'b1, OFS_COUNT_START, 32'h1);
    edge_read(1'b0, OFS_A_COUNT);
    chk("event underflow read", rd, 32'(RD_UNDER));
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    $display("test event done");
    xfer(1'b1, OFS_B_MODE, 32'h3);
    xfer(1'b1, OFS_B_COUNT, 32'hFFFD);
    xfer(1'b1, OFS_IRQ, 32'h3);
    xfer(1'b1, OFS_COUNT_START, 32'h2);
    wait_lvl(2, 1'b1, 40);
    // First clear lands before a count tick has passed since the overflow
    xfer(1'b1, OFS_B_MODE, 32'h3);
    xfer(1'b0, OFS_B_MODE, 32'h0);
    chk("overflow kept", 32'(rd[OVF_BIT]), 32'h1);
    xfer(1'b1, OFS_B_MODE, 32'h3);
    xfer(1'b0, OFS_B_MODE, 32'h0);
    chk("overflow cleared", 32'(rd[OVF_BIT]), 32'h0);
    xfer(1'b1, OFS_IRQ, 32'h3);
    repeat (20) @(negedge clk_i);
    pins.set_pins(1'b1, 1'b1);
    repeat (3) @(negedge clk_i);
    chk("first edge flag", 32'(ir_b_o), 32'h0);
    repeat (20) @(negedge clk_i);
    pins.set_pins(1'b0, 1'b1);
    repeat (3) @(negedge clk_i);
    chk("width edge flag", 32'(ir_b_o), 32'h1);
    xfer(1'b0, OFS_B_COUNT, 32'h0);
    chk("high width", 32'(rd > 32'h3 && rd < 32'h8), 32'h1);
    xfer(1'b1, OFS_IRQ, 32'h3);
    xfer(1'b1, OFS_B_MODE, 32'h3);
    @(negedge clk_i);
    chk("same select flag", 32'(ir_b_o), 32'h0);
    xfer(1'b1, OFS_B_MODE, 32'h2);
    @(negedge clk_i);
    chk("new select flag", 32'(ir_b_o), 32'h1);
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    xfer(1'b1, OFS_B_MODE, 32'h1);
    xfer(1'b1, OFS_B_COUNT, 32'h0);
    xfer(1'b1, OFS_COUNT_START, 32'h2);
    edge_read(1'b1, OFS_B_COUNT);
    chk("B event reload read", rd, 32'(RD_UNDER));
    xfer(1'b1, OFS_COUNT_START, 32'h0);
    $display("test measure done");
    xfer(1'b1, OFS_MOTOR, 32'hE);
    pins.set_pins(1'b0, 1'b0);
    repeat (3) @(negedge clk_i);
    chk("no shutdown", 32'(motor_o.oe), 32'h7);
    xfer(1'b1, OFS_MOTOR, 32'hF);
    repeat (3) @(negedge clk_i);
    chk("shutdown", 32'(motor_o.oe), 32'h0);
    $display("test shutdown done");
    end_sim();
  end
endmodule : multimode_timer_unit_test
